// ===== sbt_pkg.sv
// Functional notes
// - Unconnected data-in and mode-select inputs read as logic high.
// - Power-up leaves the test logic in reset, memory operation undisturbed.
// - Inputs sampled on test-clock rise, outputs updated on test-clock fall.
// - Controller transitions depend only on mode select sampled at clock rise.
// - Current instruction selects the register between data in and out.
// - Only one register sits in the serial path at any time.
// - Data enters at the MSB; the LSB drives the serial output.
// - Serial output driven only in shift states, else off; changes on fall.
// - Five rising edges with mode select high reach reset from any state.
// - Test-port reset never affects normal memory function.
// - Power-up resets the controller without any test clock; output off.
// - Three-bit instruction register loads identification on reset.
// - Instruction capture loads 01 into the two low instruction bits.
// - Single-bit bypass register, captured low, used under bypass.
// - Identification instruction captures and shifts a fixed 32-bit code.
package sbt_pkg;

	// Instruction register layout and codes
	localparam int          IR_W           = 3;
	localparam logic [2:0]  INS_EXTEST     = 3'h0;
	localparam logic [2:0]  INS_IDCODE     = 3'h1;
	localparam logic [2:0]  INS_SAMPLE_Z   = 3'h2;
	localparam logic [2:0]  INS_SAMPLE_PRE = 3'h4;
	localparam logic [2:0]  INS_BYPASS     = 3'h7;
	localparam logic [2:0]  IR_CAPT_VAL    = 3'h1;

	// Data register sizes and capture values
	localparam int          ID_W           = 32;
	localparam int          BSR_LEN_DEF    = 64;
	localparam logic        BYP_CAPT_VAL   = 1'h0;

	// Synchroniser reset levels: test clock low, mode select and data high
	localparam logic [2:0]  SYNC_RST       = 3'h3;
	localparam int          SYNC_TCK       = 2;
	localparam int          SYNC_TMS       = 1;
	localparam int          SYNC_TDI       = 0;

	// Serial output reset levels
	localparam logic        TDO_RST        = 1'h0;
	localparam logic        TDO_OE_N_OFF   = 1'h1;

	// Controller states, Gray-coded along the usual path
	typedef enum logic [3:0] {
		ST_RESET    = 4'h0,
		ST_IDLE     = 4'h1,
		ST_SEL_DR   = 4'h3,
		ST_CAP_DR   = 4'h2,
		ST_SH_DR    = 4'h6,
		ST_EX1_DR   = 4'h7,
		ST_PAUSE_DR = 4'h5,
		ST_EX2_DR   = 4'h4,
		ST_UPD_DR   = 4'hc,
		ST_SEL_IR   = 4'hd,
		ST_CAP_IR   = 4'hf,
		ST_SH_IR    = 4'he,
		ST_EX1_IR   = 4'ha,
		ST_PAUSE_IR = 4'hb,
		ST_EX2_IR   = 4'h9,
		ST_UPD_IR   = 4'h8
	} sbt_state_type;

endpackage

// ===== sbt_tap_if.sv
interface sbt_tap_if;
	logic                   tck_rise;
	logic                   tms;
	sbt_pkg::sbt_state_type state;

	modport ctrl
	(
		input  tck_rise,
		input  tms,
		output state
	);

	modport user
	(
		output tck_rise,
		output tms,
		input  state
	);
endinterface

// ===== sbt_tap_fsm.sv
module sbt_tap_fsm
(
	input  wire logic  i_clk_sys,
	input  wire logic  i_rst,
	input  wire logic  i_ce,
	sbt_tap_if.ctrl    tap
);

	sbt_pkg::sbt_state_type state_q;
	sbt_pkg::sbt_state_type state_d;
	sbt_pkg::sbt_state_type state_nx;

	// Next state from mode select alone
	always_comb
	begin
		state_nx = sbt_pkg::ST_RESET;
		case (state_q)
			sbt_pkg::ST_RESET:    state_nx = tap.tms ? sbt_pkg::ST_RESET : sbt_pkg::ST_IDLE;
			sbt_pkg::ST_IDLE:     state_nx = tap.tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
			sbt_pkg::ST_SEL_DR:   state_nx = tap.tms ? sbt_pkg::ST_SEL_IR : sbt_pkg::ST_CAP_DR;
			sbt_pkg::ST_CAP_DR:   state_nx = tap.tms ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_SH_DR:    state_nx = tap.tms ? sbt_pkg::ST_EX1_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_EX1_DR:   state_nx = tap.tms ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_PAUSE_DR;
			sbt_pkg::ST_PAUSE_DR: state_nx = tap.tms ? sbt_pkg::ST_EX2_DR : sbt_pkg::ST_PAUSE_DR;
			sbt_pkg::ST_EX2_DR:   state_nx = tap.tms ? sbt_pkg::ST_UPD_DR : sbt_pkg::ST_SH_DR;
			sbt_pkg::ST_UPD_DR:   state_nx = tap.tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
			sbt_pkg::ST_SEL_IR:   state_nx = tap.tms ? sbt_pkg::ST_RESET : sbt_pkg::ST_CAP_IR;
			sbt_pkg::ST_CAP_IR:   state_nx = tap.tms ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_SH_IR:    state_nx = tap.tms ? sbt_pkg::ST_EX1_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_EX1_IR:   state_nx = tap.tms ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_PAUSE_IR;
			sbt_pkg::ST_PAUSE_IR: state_nx = tap.tms ? sbt_pkg::ST_EX2_IR : sbt_pkg::ST_PAUSE_IR;
			sbt_pkg::ST_EX2_IR:   state_nx = tap.tms ? sbt_pkg::ST_UPD_IR : sbt_pkg::ST_SH_IR;
			sbt_pkg::ST_UPD_IR:   state_nx = tap.tms ? sbt_pkg::ST_SEL_DR : sbt_pkg::ST_IDLE;
			default:              state_nx = sbt_pkg::ST_RESET;
		endcase
	end

	// Advance only on a detected test-clock rise
	assign state_d   = tap.tck_rise ? state_nx : state_q;
	assign tap.state = state_q;

	// State register; reset needs no test clock
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			state_q <= sbt_pkg::ST_RESET;
		else if (i_ce)
			state_q <= state_d;
	end

endmodule

// ===== sbt_tap_top.sv
module sbt_tap_top
#(
	parameter int                  BSR_LEN = sbt_pkg::BSR_LEN_DEF,
	parameter logic [31:0]         ID_CODE = 32'h1a5c_e001
)
(
	input  wire logic                i_clk_sys,
	input  wire logic                i_rst,
	input  wire logic                i_ce,
	input  wire logic                i_tck,
	input  wire logic                i_tms,
	input  wire logic                i_tdi,
	input  wire logic [BSR_LEN-1:0]  i_bsr_capture,
	output logic                     o_tdo,
	output logic                     o_tdo_oe_n,
	output logic [BSR_LEN-1:0]       o_bsr_update,
	output logic [2:0]               o_ir,
	output logic                     o_extest,
	output logic                     o_sample_z
);

	// ID_CODE default above is an arbitrary value

	// Carrier between this module and the controller
	sbt_tap_if tap ();

	// Pin synchronisers: stage one feeds stage two only
	logic [2:0]                    sync1_q;
	logic [2:0]                    sync2_q;
	logic                          tck3_q;

	// Test clock edges and sampled pins
	logic                          tck_s;
	logic                          tms_s;
	logic                          tdi_s;
	logic                          tck_rise;
	logic                          tck_fall;

	// Controller state decodes
	logic                          st_reset;
	logic                          st_cap_ir;
	logic                          st_sh_ir;
	logic                          st_upd_ir;
	logic                          st_cap_dr;
	logic                          st_sh_dr;
	logic                          st_upd_dr;
	logic                          in_shift;

	// Per-edge strobes for the test registers
	logic                          ir_cap;
	logic                          ir_shift;
	logic                          ir_load;
	logic                          dr_cap;
	logic                          dr_shift;
	logic                          bsr_load;
	logic                          tdo_load;

	// Next mode flags and the instruction chain's low bit
	logic                          nx_extest;
	logic                          nx_sample_z;
	logic                          ir_lsb;

	// Instruction decode and register selection
	logic                          sel_id;
	logic                          sel_bsr;
	logic                          sel_byp;
	logic                          ins_extest;
	logic                          ins_sample_z;
	logic                          ins_preload;

	// Instruction shift and active registers
	logic [sbt_pkg::IR_W-1:0]      ir_sh_q;
	logic [sbt_pkg::IR_W-1:0]      ir_sh_d;
	logic [sbt_pkg::IR_W-1:0]      ir_q;
	logic [sbt_pkg::IR_W-1:0]      ir_d;

	// Data registers
	logic [sbt_pkg::ID_W-1:0]      id_sh_q;
	logic [sbt_pkg::ID_W-1:0]      id_sh_d;
	logic                          byp_q;
	logic                          byp_d;
	logic [BSR_LEN-1:0]            bsr_sh_q;
	logic [BSR_LEN-1:0]            bsr_sh_d;
	logic [BSR_LEN-1:0]            bsr_upd_q;
	logic [BSR_LEN-1:0]            bsr_upd_d;

	// Serial output path
	logic                          dr_lsb;
	logic                          ser_out;
	logic                          tdo_q;
	logic                          tdo_d;
	logic                          tdo_oe_n_q;
	logic                          tdo_oe_n_d;
	logic                          extest_q;
	logic                          sample_z_q;

	// First synchroniser stage; reset to the idle pin levels
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			sync1_q <= sbt_pkg::SYNC_RST;
		else if (i_ce)
			sync1_q <= {i_tck, i_tms, i_tdi};
	end

	// Second synchroniser stage reads only the first
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			sync2_q <= sbt_pkg::SYNC_RST;
		else if (i_ce)
			sync2_q <= sync1_q;
	end

	// Third tap on the test clock for edge detection
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			tck3_q <= sbt_pkg::SYNC_RST[sbt_pkg::SYNC_TCK];
		else if (i_ce)
			tck3_q <= sync2_q[sbt_pkg::SYNC_TCK];
	end

	// Edge detection on the synchronised test clock
	assign tck_s    = sync2_q[sbt_pkg::SYNC_TCK];
	assign tms_s    = sync2_q[sbt_pkg::SYNC_TMS];
	assign tdi_s    = sync2_q[sbt_pkg::SYNC_TDI];
	assign tck_rise = tck_s & ~tck3_q;
	assign tck_fall = ~tck_s & tck3_q;

	// Feed the controller
	assign tap.tck_rise = tck_rise;
	assign tap.tms      = tms_s;

	sbt_tap_fsm u_fsm
	(
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_ce      (i_ce),
		.tap       (tap.ctrl)
	);

	// State decodes
	assign st_reset  = (tap.state == sbt_pkg::ST_RESET);
	assign st_cap_ir = (tap.state == sbt_pkg::ST_CAP_IR);
	assign st_sh_ir  = (tap.state == sbt_pkg::ST_SH_IR);
	assign st_upd_ir = (tap.state == sbt_pkg::ST_UPD_IR);
	assign st_cap_dr = (tap.state == sbt_pkg::ST_CAP_DR);
	assign st_sh_dr  = (tap.state == sbt_pkg::ST_SH_DR);
	assign st_upd_dr = (tap.state == sbt_pkg::ST_UPD_DR);
	assign in_shift  = st_sh_ir | st_sh_dr;

	// Active instruction decode; reserved codes fall to bypass
	assign ins_extest   = (ir_q == sbt_pkg::INS_EXTEST);
	assign ins_sample_z = (ir_q == sbt_pkg::INS_SAMPLE_Z);
	assign ins_preload  = (ir_q == sbt_pkg::INS_SAMPLE_PRE);
	assign sel_id       = (ir_q == sbt_pkg::INS_IDCODE);
	assign sel_bsr      = ins_extest | ins_sample_z | ins_preload;
	assign sel_byp      = ~sel_id & ~sel_bsr;

	// Rise strobes: capture and shift
	assign ir_cap   = tck_rise & st_cap_ir;
	assign ir_shift = tck_rise & st_sh_ir;
	assign dr_cap   = tck_rise & st_cap_dr;
	assign dr_shift = tck_rise & st_sh_dr;

	// Fall strobes: update and output
	assign ir_load  = tck_fall & st_upd_ir;
	assign bsr_load = tck_fall & st_upd_dr & (ins_extest | ins_preload);
	assign tdo_load = tck_fall & in_shift;

	// Instruction shift chain: capture pattern, shift toward bit zero
	assign ir_sh_d = ir_cap   ? sbt_pkg::IR_CAPT_VAL :
	                 ir_shift ? {tdi_s, ir_sh_q[sbt_pkg::IR_W-1:1]} :
	                 ir_sh_q;

	// Active instruction: identification in reset, else update on fall
	assign ir_d = st_reset ? sbt_pkg::INS_IDCODE :
	              ir_load  ? ir_sh_q :
	              ir_q;

	// Mode flags decoded from the next active instruction
	assign nx_extest   = (ir_d == sbt_pkg::INS_EXTEST);
	assign nx_sample_z = (ir_d == sbt_pkg::INS_SAMPLE_Z);

	// Identification register: fixed code captured, then shifted
	assign id_sh_d = (dr_cap & sel_id)   ? ID_CODE :
	                 (dr_shift & sel_id) ? {tdi_s, id_sh_q[sbt_pkg::ID_W-1:1]} :
	                 id_sh_q;

	// Bypass bit: captured low, single-stage shift
	assign byp_d = (dr_cap & sel_byp)   ? sbt_pkg::BYP_CAPT_VAL :
	               (dr_shift & sel_byp) ? tdi_s :
	               byp_q;

	// Boundary register: parallel capture, serial shift, latch on update under extest or preload
	assign bsr_sh_d  = (dr_cap & sel_bsr)   ? i_bsr_capture :
	                   (dr_shift & sel_bsr) ? {tdi_s, bsr_sh_q[BSR_LEN-1:1]} :
	                   bsr_sh_q;
	assign bsr_upd_d = bsr_load ? bsr_sh_q : bsr_upd_q;

	// One register's low bit reaches the output
	assign ir_lsb  = ir_sh_q[0];
	assign dr_lsb  = sel_id  ? id_sh_q[0] :
	                 sel_bsr ? bsr_sh_q[0] :
	                 byp_q;
	assign ser_out = st_sh_ir ? ir_lsb : dr_lsb;

	// Output drive decided on the falling edge only
	assign tdo_d      = tdo_load ? ser_out : tdo_q;
	assign tdo_oe_n_d = tck_fall ? ~in_shift : tdo_oe_n_q;

	// Instruction shift chain
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			ir_sh_q <= sbt_pkg::INS_IDCODE;
		else if (i_ce)
			ir_sh_q <= ir_sh_d;
	end

	// Active instruction; identification from power-up
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			ir_q <= sbt_pkg::INS_IDCODE;
		else if (i_ce)
			ir_q <= ir_d;
	end

	// Identification shift register
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			id_sh_q <= '0;
		else if (i_ce)
			id_sh_q <= id_sh_d;
	end

	// Bypass bit
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			byp_q <= sbt_pkg::BYP_CAPT_VAL;
		else if (i_ce)
			byp_q <= byp_d;
	end

	// Boundary shift chain
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			bsr_sh_q <= '0;
		else if (i_ce)
			bsr_sh_q <= bsr_sh_d;
	end

	// Boundary update latch; a controller reset leaves it alone
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			bsr_upd_q <= '0;
		else if (i_ce)
			bsr_upd_q <= bsr_upd_d;
	end

	// Serial output value
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			tdo_q <= sbt_pkg::TDO_RST;
		else if (i_ce)
			tdo_q <= tdo_d;
	end

	// Serial output enable; off from power-up
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			tdo_oe_n_q <= sbt_pkg::TDO_OE_N_OFF;
		else if (i_ce)
			tdo_oe_n_q <= tdo_oe_n_d;
	end

	// External test flag, in step with the instruction
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			extest_q <= 1'h0;
		else if (i_ce)
			extest_q <= nx_extest;
	end

	// Sample-z flag, in step with the instruction
	always_ff @(posedge i_clk_sys)
	begin
		if (i_rst)
			sample_z_q <= 1'h0;
		else if (i_ce)
			sample_z_q <= nx_sample_z;
	end

	// Test-port state only; memory path is never touched here
	assign o_tdo        = tdo_q;
	assign o_tdo_oe_n   = tdo_oe_n_q;
	assign o_bsr_update = bsr_upd_q;
	assign o_ir         = ir_q;
	assign o_extest     = extest_q;
	assign o_sample_z   = sample_z_q;

endmodule

// ===== sbt_tap_top_chk.sv
module sbt_tap_top_chk
#(
	parameter int BSR_LEN = 64
)
(
	input  wire logic               i_clk_sys,
	input  wire logic               i_rst,
	input  wire logic               i_tck,
	input  wire logic               o_tdo,
	input  wire logic               o_tdo_oe_n,
	input  wire logic [BSR_LEN-1:0] o_bsr_update,
	input  wire logic [2:0]         o_ir,
	input  wire logic               o_extest,
	input  wire logic               o_sample_z
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	logic [3:0] low_cnt_q;
	logic [3:0] low_cnt_d;

	// Counts system cycles with the test clock held low
	assign low_cnt_d = (low_cnt_q == 4'hf) ? low_cnt_q : low_cnt_q + 4'h1;
	always_ff @(posedge i_clk_sys)
		low_cnt_q <= (i_rst || i_tck) ? 4'h0 : low_cnt_d;

	a_rst_outputs: assert property ($fell(i_rst) |-> o_tdo_oe_n && o_ir == sbt_pkg::INS_IDCODE && !o_extest)
		else $error("outputs not at reset values after reset");
	a_extest_decode: assert property (o_extest == (o_ir == sbt_pkg::INS_EXTEST))
		else $error("extest flag does not match instruction");
	a_samplez_decode: assert property (o_sample_z == (o_ir == sbt_pkg::INS_SAMPLE_Z))
		else $error("sample z flag does not match instruction");
	a_tdo_on_fall: assert property ((!$stable(o_tdo) || !$stable(o_tdo_oe_n)) |-> !i_tck && !$past(i_tck))
		else $error("serial output changed outside test clock low phase");
	a_ir_on_fall: assert property (!$stable(o_ir) && o_ir != sbt_pkg::INS_IDCODE |-> !i_tck)
		else $error("instruction changed outside test clock low phase");
	a_bsr_on_fall: assert property (!$stable(o_bsr_update) && o_ir != sbt_pkg::INS_IDCODE
		|-> !i_tck && (o_extest || o_ir == sbt_pkg::INS_SAMPLE_PRE))
		else $error("boundary latch updated at wrong time");
	a_quiet_link: assert property (low_cnt_q >= 4'h8 |-> $stable(o_tdo) && $stable(o_tdo_oe_n) && $stable(o_ir))
		else $error("outputs moved without test clock");
	a_oe_hold: assert property (!$stable(o_tdo_oe_n) |=> $stable(o_tdo_oe_n) [*4])
		else $error("output enable toggled too fast");

	c_shift_out: cover property ($fell(o_tdo_oe_n));
	c_extest: cover property ($rose(o_extest));
	c_bsr_load: cover property (!$stable(o_bsr_update));
endmodule

bind sbt_tap_top sbt_tap_top_chk #(.BSR_LEN(BSR_LEN)) sbt_tap_top_chk_i
(
	.i_clk_sys    (i_clk_sys),
	.i_rst        (i_rst),
	.i_tck        (i_tck),
	.o_tdo        (o_tdo),
	.o_tdo_oe_n   (o_tdo_oe_n),
	.o_bsr_update (o_bsr_update),
	.o_ir         (o_ir),
	.o_extest     (o_extest),
	.o_sample_z   (o_sample_z)
);

// ===== sbt_tap_host.sv
module sbt_tap_host
(
	input  wire logic i_clk_sys,
	input  wire logic i_tdo,
	input  wire logic i_tdo_oe_n,
	output logic      o_tck,
	output logic      o_tms,
	output logic      o_tdi
);
	timeunit 1ns;
	timeprecision 1ps;

	logic tms_q;
	logic tdi_q;
	logic drv_q;

	// Released pins float to their pull-up level
	assign o_tms = drv_q ? tms_q : 1'h1;
	assign o_tdi = drv_q ? tdi_q : 1'h1;

	// Test clock rests low between frames
	initial
	begin
		o_tck = 1'h0;
		tms_q = 1'h1;
		tdi_q = 1'h1;
		drv_q = 1'h0;
	end

	// One 200 ns test clock period; output read just before the rise
	task automatic step(input logic tms, input logic tdi, input logic en, output logic tdo, output logic oe_n);
		tms_q <= tms;
		tdi_q <= tdi;
		drv_q <= en;
		repeat (4) @(posedge i_clk_sys);
		// A line left undriven reads as the inverse of its last value
		tdo = i_tdo_oe_n ? ~i_tdo : i_tdo;
		oe_n = i_tdo_oe_n;
		o_tck <= 1'h1;
		repeat (4) @(posedge i_clk_sys);
		o_tck <= 1'h0;
	endtask
endmodule

// ===== sbt_tap_top_tb_top.sv
module sbt_tap_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] ID_VAL = 32'h0bad_5eed; // Arbitrary value

	logic        clk_sys = 1'h0;
	logic        rst = 1'h1;
	logic        ce = 1'h1;
	logic        tck;
	logic        tms;
	logic        tdi;
	logic        tdo;
	logic        tdo_oe_n;
	logic [7:0]  bsr_upd;
	logic [2:0]  ir;
	logic        extest;
	logic        sample_z;
	logic [63:0] so;
	logic [63:0] se;
	int          err_count = 0;
	int          checks = 0;

	always #12.5 clk_sys = ~clk_sys;

	sbt_tap_top #(.BSR_LEN(8), .ID_CODE(ID_VAL)) sbt_tap_top_i
	(
		.i_clk_sys     (clk_sys),
		.i_rst         (rst),
		.i_ce          (ce),
		.i_tck         (tck),
		.i_tms         (tms),
		.i_tdi         (tdi),
		.i_bsr_capture (8'h5c),
		.o_tdo         (tdo),
		.o_tdo_oe_n    (tdo_oe_n),
		.o_bsr_update  (bsr_upd),
		.o_ir          (ir),
		.o_extest      (extest),
		.o_sample_z    (sample_z)
	);

	sbt_tap_host sbt_tap_host_i
	(
		.i_clk_sys  (clk_sys),
		.i_tdo      (tdo),
		.i_tdo_oe_n (tdo_oe_n),
		.o_tck      (tck),
		.o_tms      (tms),
		.o_tdi      (tdi)
	);

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Runs n test clock periods, bit i of each vector at rise i
	task automatic seq(input int n, input logic [63:0] vms, input logic [63:0] vdi, input logic en);
		for (int i = 0; i < n; i++)
			sbt_tap_host_i.step(vms[i], vdi[i], en, so[i], se[i]);
	endtask

	// Loads an instruction from idle or reset, previous one held until update
	task automatic t_ir(input logic [2:0] ins, input logic [2:0] prev);
		seq(8, 64'h86, {56'h0, ins, 5'h0}, 1'h1);
		check("ir capture", 3'h1, so[7:5]);
		check("ir before update", prev, ir);
		seq(2, 64'h1, 64'h0, 1'h1);
		check("ir after update", ins, ir);
	endtask

	// Capture and shift out the identification code
	task automatic t_idcode();
		seq(38, 64'h18_0000_0002, 64'h0, 1'h1);
		check("idcode", ID_VAL, so[35:4]);
		check("enable in shift", 32'h0, se[35:4]);
		check("enable before shift", 1'h1, se[3]);
		check("enable after shift", 1'h1, se[36]);
	endtask

	// Single-bit path under bypass
	task automatic t_bypass();
		t_ir(sbt_pkg::INS_BYPASS, sbt_pkg::INS_IDCODE);
		seq(10, 64'h182, 64'h50, 1'h1);
		check("bypass stream", 4'ha, so[7:4]);
	endtask

	// Boundary capture, shift and update under the external test
	task automatic t_extest();
		t_ir(sbt_pkg::INS_EXTEST, sbt_pkg::INS_BYPASS);
		check("extest flag", 1'h1, extest);
		seq(14, 64'h1802, 64'ha30, 1'h1);
		check("boundary capture", 8'h5c, so[11:4]);
		check("boundary update", 8'ha3, bsr_upd);
		t_ir(sbt_pkg::INS_SAMPLE_Z, sbt_pkg::INS_EXTEST);
		check("sample z flag", 1'h1, sample_z);
	endtask

	// Released pins from shift state bring the controller back to reset
	task automatic t_tms_reset();
		seq(4, 64'h2, 64'h0, 1'h1);
		seq(5, 64'h0, 64'h0, 1'h0);
		check("enable in shift", 1'h0, se[0]);
		repeat (4) @(posedge clk_sys);
		check("ir after tms reset", sbt_pkg::INS_IDCODE, ir);
		check("sample z after reset", 1'h0, sample_z);
		check("enable after reset", 1'h1, tdo_oe_n);
	endtask

	// Clock enable low freezes the port: five mode-select-high rises are lost
	task automatic t_freeze();
		ce <= 1'h0;
		seq(5, 64'h1f, 64'h0, 1'h1);
		ce <= 1'h1;
		check("ir while frozen", sbt_pkg::INS_SAMPLE_Z, ir);
		check("enable while frozen", 1'h1, tdo_oe_n);
	endtask

	// Mid-run reset with no test clock returns outputs to reset values
	task automatic t_hard_reset();
		t_ir(sbt_pkg::INS_EXTEST, sbt_pkg::INS_IDCODE);
		check("boundary kept", 8'ha3, bsr_upd);
		rst <= 1'h1;
		repeat (3) @(posedge clk_sys);
		rst <= 1'h0;
		repeat (4) @(posedge clk_sys);
		check("ir after hard reset", sbt_pkg::INS_IDCODE, ir);
		check("extest after hard reset", 1'h0, extest);
		check("boundary after hard reset", 8'h0, bsr_upd);
		check("enable after hard reset", 1'h1, tdo_oe_n);
	endtask

	// Watchdog on the whole run
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		conclude();
	end

	initial
	begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'h0;
		repeat (10) @(posedge clk_sys);
		check("ir at reset", sbt_pkg::INS_IDCODE, ir);
		check("enable at reset", 1'h1, tdo_oe_n);
		check("extest at reset", 1'h0, extest);
		check("boundary at reset", 8'h0, bsr_upd);
		t_idcode();
		t_bypass();
		t_extest();
		t_freeze();
		t_tms_reset();
		t_hard_reset();
		conclude();
	end
endmodule
